// >>> rtl/escs_pkg.sv
/*
  Constants for the external sample clock select block: register offsets,
  reset values, range class codes and divider limits.
  Assumes a 16-bit register address and 32-bit register data.
*/
`default_nettype none
package escs_pkg;
  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 32;
  localparam int          CNT_W          = 10;
  localparam int          RANGE_W        = 6;
  localparam int          DIV_W          = 11;
  localparam logic [15:0] OFS_DIV        = 16'h4e48;
  localparam logic [15:0] OFS_SRC_SEL    = 16'h4e84;
  localparam logic [15:0] OFS_CLK_OUT    = 16'h4e8c;
  localparam logic [15:0] OFS_TERM       = 16'h4e98;
  localparam logic [15:0] OFS_RANGE      = 16'h4ea2;
  localparam logic [15:0] OFS_STATUS     = 16'h4ea8;
  localparam logic [10:0] RST_DIV        = 11'h001;
  localparam logic [5:0]  RANGE_SINGLE   = 6'h02;
  localparam logic [5:0]  RANGE_BURST_S  = 6'h04;
  localparam logic [5:0]  RANGE_BURST_M  = 6'h08;
  localparam logic [5:0]  RANGE_BURST_L  = 6'h10;
  localparam logic [5:0]  range_class_extra_large_burst = 6'h20;
  localparam logic [5:0]  RST_RANGE      = RANGE_SINGLE;
  localparam int          STAT_SAMP_BIT  = 0;
  localparam int          STAT_DRV_BIT   = 1;
  localparam int          STAT_TERM_BIT  = 2;

  // Returns one for a divider value the clock path supports.
  function automatic logic div_legal(input logic [31:0] v);
    logic ok;
    ok = 1'b0;
    case (v)
      32'h1, 32'h2, 32'h4, 32'h8, 32'ha, 32'h10, 32'h14, 32'h28, 32'h32,
      32'h50, 32'h64, 32'hc8, 32'h190, 32'h1f4, 32'h320, 32'h3e8,
      32'h7d0: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : div_legal

  // Returns one for one of the five range class codes.
  function automatic logic range_legal(input logic [31:0] v);
    return (v == 32'(RANGE_SINGLE)) || (v == 32'(RANGE_BURST_S)) ||
           (v == 32'(RANGE_BURST_M)) || (v == 32'(RANGE_BURST_L)) ||
           (v == 32'(range_class_extra_large_burst));
  endfunction : range_legal
endpackage : escs_pkg
`default_nettype wire

// >>> rtl/escs_top.sv
/*
  External sample clock select and divider with its register port.
  Assumes the connector level, the internal clock level and all register
  strobes are synchronous to mclk_i, and that the external clock runs
  well below half of mclk_i.
*/
// Overview of operation
// [R1] Source select picks connector or internal clock.
// [R2] Termination only while connector is an input.
// [R3] External clock may stop; nothing breaks.
// [R4] Source stays below model maximum rate.
// [R5] Range class holds one-hot codes 2 to 32.
// [R6] Clock stays within class, 5 % margin.
// [R7] Software picks class from channel setup.
// [R8] Channel change needs fresh range class write.
// [R9] Sample clock is external clock divided.
// [R10] Only the seventeen listed divider values.
// [R11] With divider, source faster than 1 MS/s.
// [R12] Clock drives out only under internal clocking.
// [R13] Unsupported divider write is ignored.
`timescale 1ns/10ps
`default_nettype none

module escs_top (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        clk_conn_i,
  output logic             clk_conn_o,
  output logic             clk_conn_oe_o,
  input  wire logic        int_clk_i,
  output logic             sample_clk_o,
  output logic             ext_sel_o,
  output logic             term_en_o,
  output logic      [5:0]  range_sel_o
);

  // ---------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------
  logic [10:0] div_reg;
  logic        ext_sel_reg;
  logic        clk_out_reg;
  logic        term_reg;
  logic [5:0]  range_reg;
  logic [9:0]  cnt_reg;
  logic [9:0]  cnt_next;
  logic        prev_reg;
  logic        samp_reg;
  logic        samp_next;
  logic        drive_reg;
  logic        term_out_reg;
  logic [31:0] rdata_reg;

  wire hit_div    = (addr_i == escs_pkg::OFS_DIV);
  wire hit_sel    = (addr_i == escs_pkg::OFS_SRC_SEL);
  wire hit_cko    = (addr_i == escs_pkg::OFS_CLK_OUT);
  wire hit_term   = (addr_i == escs_pkg::OFS_TERM);
  wire hit_range  = (addr_i == escs_pkg::OFS_RANGE);
  wire hit_status = (addr_i == escs_pkg::OFS_STATUS);

  wire        div_ok   = escs_pkg::div_legal(wdata_i);
  wire        range_ok = escs_pkg::range_legal(wdata_i);
  wire        wr_div   = ce_i && wr_i && hit_div && div_ok;      // see [R13]
  wire        wr_range = ce_i && wr_i && hit_range && range_ok;  // see [R5]

  wire [31:0] status_word = {29'h0, term_out_reg, drive_reg, samp_reg};

  wire [31:0] rd_mux =
    hit_div    ? {21'h0, div_reg} :
    hit_sel    ? {31'h0, ext_sel_reg} :
    hit_cko    ? {31'h0, clk_out_reg} :
    hit_term   ? {31'h0, term_reg} :
    hit_range  ? {26'h0, range_reg} :
    hit_status ? status_word : 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Sample clock path
  // ---------------------------------------------------------------------
  wire [9:0] half_div = div_reg[10:1];
  wire       ext_rise = clk_conn_i && !prev_reg;
  wire       div_one  = (div_reg == escs_pkg::RST_DIV);
  wire       half_hit = (cnt_reg == (half_div - 10'h001));

  // With no external edge the divider simply holds, so DC is legal.
  always_comb begin
    samp_next = samp_reg;
    cnt_next  = cnt_reg;
    if (!ext_sel_reg) begin
      samp_next = int_clk_i;                                     // see [R1]
      cnt_next  = 10'h000;
    end else if (div_one) begin
      samp_next = clk_conn_i;                                    // see [R1]
      cnt_next  = 10'h000;
    end else if (ext_rise) begin                                 // see [R3]
      if (half_hit) begin
        samp_next = !samp_reg;                                   // see [R9]
        cnt_next  = 10'h000;
      end else begin
        cnt_next  = cnt_reg + 10'h001;
      end
    end
  end

  // Drive and termination register together, so they never overlap at the pin.
  wire drive_next = !ext_sel_reg && clk_out_reg;                 // see [R12]
  wire term_next  = term_reg && !drive_next;                     // see [R2]

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg     <= escs_pkg::RST_DIV;
      ext_sel_reg <= 1'b0;
      clk_out_reg <= 1'b0;
      term_reg    <= 1'b0;
      range_reg   <= escs_pkg::RST_RANGE;
    end else if (ce_i) begin
      if (wr_div)
        div_reg <= wdata_i[10:0];                                // see [R10]
      if (wr_i && hit_sel)
        ext_sel_reg <= wdata_i[0];
      if (wr_i && hit_cko)
        clk_out_reg <= wdata_i[0];
      if (wr_i && hit_term)
        term_reg <= wdata_i[0];
      if (wr_range)
        range_reg <= wdata_i[5:0];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg      <= 10'h000;
      prev_reg     <= 1'b0;
      samp_reg     <= 1'b0;
      drive_reg    <= 1'b0;
      term_out_reg <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
    end else if (ce_i) begin
      cnt_reg      <= wr_div ? 10'h000 : cnt_next;
      prev_reg     <= clk_conn_i;
      samp_reg     <= samp_next;
      drive_reg    <= drive_next;
      term_out_reg <= term_next;
      rdata_reg    <= rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata_o       = rdata_reg;
  assign sample_clk_o  = samp_reg;
  assign clk_conn_o    = samp_reg;
  assign clk_conn_oe_o = drive_reg;
  assign ext_sel_o     = ext_sel_reg;
  assign term_en_o     = term_out_reg;
  assign range_sel_o   = range_reg;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  chk_ext_direct: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R1]
    (ce_i && ext_sel_reg && div_one) |=> (samp_reg == $past(clk_conn_i)))
    else $error("external clock not passed through");

  chk_int_path: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R1]
    (ce_i && !ext_sel_reg) |=> (samp_reg == $past(int_clk_i)))
    else $error("internal clock not selected");

  chk_term_input: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R2]
    term_en_o |-> !clk_conn_oe_o)
    else $error("termination on while connector drives");

  chk_dc_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R3]
    (ce_i && ext_sel_reg && !div_one && !ext_rise) |=> $stable(samp_reg))
    else $error("divided clock moved without an input edge");

  chk_range_code: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R5]
    (range_sel_o != 6'h00) && ((range_sel_o & (range_sel_o - 6'h01)) == 6'h00)
    && !range_sel_o[0])
    else $error("range class is not a valid one-hot code");

  chk_div_toggle: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R9]
    (ce_i && ext_sel_reg && !div_one && ext_rise && half_hit && !wr_div)
    |=> (samp_reg != $past(samp_reg)) && (cnt_reg == 10'h000))
    else $error("divided clock missed its toggle");

  chk_div_set: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R10]
    escs_pkg::div_legal({21'h0, div_reg}))
    else $error("divider holds an unsupported value");

  chk_oe_internal: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R12]
    (ce_i && $past(ce_i) && $past(ext_sel_reg)) |-> !clk_conn_oe_o)
    else $error("connector driven under external clocking");

  chk_div_ignore: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R13]
    (ce_i && wr_i && hit_div && !div_ok) |=> $stable(div_reg))
    else $error("unsupported divider write took effect");

  chk_term_follow: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R2]
    (ce_i && term_reg && !drive_next) |=> term_en_o)
    else $error("termination missing on an input connector");

  chk_range_ignore: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R5]
    (ce_i && wr_i && hit_range && !range_ok) |=> $stable(range_reg))
    else $error("unsupported range class write took effect");

  chk_cnt_bound: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R9]
    (ext_sel_reg && !div_one) |-> (cnt_reg < half_div))
    else $error("divider count passed its half period");

  chk_oe_follow: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R12]
    (ce_i && !ext_sel_reg && clk_out_reg) |=> clk_conn_oe_o)
    else $error("connector not driven under internal clocking");

endmodule : escs_top

`default_nettype wire

// >>> verif/escs_ext_gen.sv
/* External clock generator model driving the clock connector.
   Assumes mclk_i as time base; the level changes after rising edges. */
`timescale 1ns/10ps
`default_nettype none
module escs_ext_gen (
  input  wire logic       mclk_i,
  input  wire logic       run_i,
  input  wire logic [3:0] half_i,
  output var logic        clk_o
);
  logic [3:0] cnt = 4'h0;
  logic       lvl = 1'b0;
  assign clk_o = lvl;
  // A slow clock that may stop, far under the top rate.
  always @(posedge mclk_i) begin
    if (!run_i) begin
      cnt <= 4'h0;
    end else if (cnt >= half_i) begin
      cnt <= 4'h0;
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : escs_ext_gen
`default_nettype wire

// >>> verif/testbench.sv
/* Self-checking bench for the external sample clock select block.
   Assumes escs_pkg and escs_top; a generator model feeds the connector. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        run = 1'b1;
  logic        ce = 1'b1;
  logic        int_clk = 1'b0;
  logic        gen_clk;
  logic        conn;
  logic [31:0] rdata;
  logic        c_o, c_oe, samp, ext, term;
  logic [5:0]  rng;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  initial forever #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) int_clk <= ~int_clk;
  assign conn = c_oe ? c_o : gen_clk;
  escs_ext_gen GEN (.mclk_i(mclk_i), .run_i(run), .half_i(4'h2), .clk_o(gen_clk));
  escs_top DUT (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .clk_conn_i(conn),
    .clk_conn_o(c_o), .clk_conn_oe_o(c_oe), .int_clk_i(int_clk),
    .sample_clk_o(samp), .ext_sel_o(ext), .term_en_o(term), .range_sel_o(rng));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask : rd_reg
  task automatic settle;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask : settle
  // Cycles between two toggles of the sample clock, zero if it holds.
  task automatic span(output int n);
    int t, k;
    logic s;
    k = 0;
    n = 0;
    @(posedge mclk_i);
    #1 s = samp;
    for (t = 1; t < 300 && k < 2; t++) begin
      @(posedge mclk_i);
      #1;
      if (samp !== s) begin
        s = samp;
        n = t - n;
        k++;
      end
    end
  endtask : span
  task automatic t_range;
    logic [5:0] c [5] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    rd_reg(escs_pkg::OFS_RANGE, 32'h2);
    rd_reg(16'h4e00, 32'h0);
    foreach (c[i]) begin
      wr_reg(escs_pkg::OFS_RANGE, 32'(c[i]));
      settle();
      chk("range", 32'(rng), 32'(c[i]));
      rd_reg(escs_pkg::OFS_RANGE, 32'(c[i]));
    end
    wr_reg(escs_pkg::OFS_RANGE, 32'h3);
    rd_reg(escs_pkg::OFS_RANGE, 32'h20);
    $display("range test done");
  endtask : t_range
  task automatic t_conn;
    int n;
    chk("oe", 32'(c_oe), 32'h0);
    wr_reg(escs_pkg::OFS_CLK_OUT, 32'h1);
    wr_reg(escs_pkg::OFS_TERM, 32'h1);
    settle();
    chk("oe", 32'(c_oe), 32'h1);
    chk("term", 32'(term), 32'h0);
    span(n);
    chk("int", 32'(n), 32'h1);
    chk("cout", 32'(c_o), 32'(samp));
    rd_reg(escs_pkg::OFS_CLK_OUT, 32'h1);
    wr_reg(escs_pkg::OFS_SRC_SEL, 32'h1);
    settle();
    chk("ext", 32'(ext), 32'h1);
    chk("oe", 32'(c_oe), 32'h0);
    chk("term", 32'(term), 32'h1);
    rd_reg(escs_pkg::OFS_SRC_SEL, 32'h1);
    rd_reg(escs_pkg::OFS_TERM, 32'h1);
    $display("connector test done");
  endtask : t_conn
  task automatic t_div;
    int d [4] = '{1, 2, 10, 16};
    int n;
    rd_reg(escs_pkg::OFS_DIV, 32'h1);
    foreach (d[i]) begin
      wr_reg(escs_pkg::OFS_DIV, 32'(d[i]));
      span(n);
      chk("period", 32'(n), 32'(3 * d[i]));
    end
    wr_reg(escs_pkg::OFS_DIV, 32'h3);
    rd_reg(escs_pkg::OFS_DIV, 32'h10);
    run <= 1'b0;
    settle();
    span(n);
    chk("held", 32'(n), 32'h0);
    rd_reg(escs_pkg::OFS_STATUS, {29'h0, 1'h1, 1'h0, samp});
    run <= 1'b1;
    span(n);
    chk("period", 32'(n), 32'h30);
    $display("divider test done");
  endtask : t_div
  task automatic t_freeze;
    int n;
    @(posedge mclk_i);
    ce <= 1'b0;
    wr_reg(escs_pkg::OFS_DIV, 32'h2);
    span(n);
    chk("frozen", 32'(n), 32'h0);
    @(posedge mclk_i);
    ce <= 1'b1;
    rd_reg(escs_pkg::OFS_DIV, 32'h10);
    $display("clock enable test done");
  endtask : t_freeze
  task automatic end_of_test;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_range();
    t_conn();
    t_div();
    t_freeze();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
